// ### rtl/flash_seq_pkg.sv
// Package: command codes, addresses, bus timing and status bit positions
package flash_seq_pkg;
	// ==========================================
	// Unlock pattern and commands
	localparam logic [11:0] unlock_addr_a = 12'h0555;
	localparam logic [11:0] unlock_addr_b = 12'h02AA;
	localparam logic [7:0] unlock_data_a = 8'h00AA;
	localparam logic [7:0] unlock_data_b = 8'h0055;
	localparam logic [7:0] cmd_erase_setup = 8'h0080;
	localparam logic [7:0] cmd_chip_erase = 8'h0010;
	localparam logic [7:0] cmd_sector_erase = 8'h0030;
	localparam logic [7:0] cmd_buffer_load = 8'h0025;
	localparam logic [7:0] cmd_buffer_confirm = 8'h0029;
	localparam logic [7:0] cmd_abort_reset = 8'h00F0;
	localparam logic [7:0] cmd_suspend = 8'h00B0;
	localparam logic [7:0] cmd_resume = 8'h0030;
	// ==========================================
	// Buffer geometry
	localparam int buffer_words = 16;
	localparam int page_low_bits = 4;
	// ==========================================
	// Status bit positions on the data lines
	localparam int data_poll_bit = 7;
	localparam int toggle_bit = 6;
	localparam int time_limit_flag = 5;
	localparam int erase_timer_flag = 3;
	localparam int erase_toggle_bit = 2;
	localparam int buffer_abort_flag = 1;
	// ==========================================
	// Timing at 40 MHz
	localparam int clock_mhz = 40;
	localparam int strobe_cycles = 4;
	localparam int window_us = 50;
	localparam int window_cycles = window_us * clock_mhz;
	localparam int suspend_max_us = 15;
	localparam int suspend_cycles = suspend_max_us * clock_mhz;
	// ==========================================
	// Software register map (word offsets as byte addresses)
	localparam logic [3:0] reg_command = 4'h0000;
	localparam logic [3:0] reg_address = 4'h0004;
	localparam logic [3:0] reg_data = 4'h0008;
	localparam logic [3:0] reg_status = 4'h000C;
	localparam logic [4:0] reg_buffer = 5'h0010;
	// Command register op codes
	localparam logic [2:0] op_buffer_program = 3'h0001;
	localparam logic [2:0] op_chip_erase = 3'h0002;
	localparam logic [2:0] op_sector_erase = 3'h0003;
	localparam logic [2:0] op_suspend = 3'h0004;
	localparam logic [2:0] op_resume = 3'h0005;
	localparam logic [2:0] op_abort_reset = 3'h0006;
	localparam logic [2:0] op_read = 3'h0007;
endpackage

// ### rtl/flash_seq_if.sv
// Interface: buffer memory port between sequencer and word store
interface word_store_if #(parameter int depth_bits = 4, parameter int data_bits = 16);
	logic wr_en;
	logic [depth_bits-1:0] wr_addr;
	logic [data_bits-1:0] wr_data;
	logic [depth_bits-1:0] rd_addr;
	logic [data_bits-1:0] rd_data;
	modport master(output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport store(input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ### rtl/word_store.sv
// Module: small word memory with registered read data
module word_store #(
	parameter int depth_bits = 4,
	parameter int data_bits = 16
) (
	// Clock
	input wire logic clock_in,
	// Port
	word_store_if.store port
);
	logic [data_bits-1:0] mem [0:(1<<depth_bits)-1];
	logic [data_bits-1:0] rd_q;
	always_ff @(posedge clock_in) begin
		if (port.wr_en) begin
			mem[port.wr_addr] <= port.wr_data;
		end
		rd_q <= mem[port.rd_addr];
	end
	assign port.rd_data = rd_q;
endmodule

// ### rtl/flash_seq_host.sv
// Module: host-side sequencer driving flash command cycles from Avalon-MM orders
// Overview of operation
// [RL1] Each data load counts, repeats included
// [RL2] Last load to a location wins
// [RL3] Confirm at sector address after loads
// [RL4] Poll status at last loaded address
// [RL5] Device aborts on four buffer faults
// [RL6] Abort shows buffer flag, clear limit
// [RL7] Abort reset sequence before next operation
// [RL8] No query functions while programming
// [RL9] Program never turns zero into one
// [RL10] Suspend stops programming within 15 us
// [RL11] Suspended reads only unsuspended sectors
// [RL12] Identifier mode returns to suspend
// [RL13] Resume ignores address, repeats ignored
// [RL14] Buffer programming suspends like word programming
// [RL15] Chip erase is six write cycles
// [RL16] Erase preprograms itself, host does nothing
// [RL17] Erase done returns to array read
// [RL18] Chip erase ignores commands, reset aborts
// [RL19] Sector erase is six write cycles
// [RL20] Extra sectors within 50 us window
// [RL21] Other command in window aborts
// [RL22] Erase timer flag shows window expiry
// [RL23] Buffer holds 16, announce count minus one
// [RL24] Page fixed by first load address
// [RL25] B0 suspends, valid during sector erase
// [RL26] Unlock AA/555, 55/2AA, command codes
//
// The register offsets and register access over Avalon-MM were left to the implementer.
module flash_seq_host #(
	parameter int addr_bits = 22,
	parameter int window_cycles = flash_seq_pkg::window_cycles
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Flash pins
	output logic [addr_bits-1:0] flash_addr_out,
	input wire logic [15:0] flash_dq_in,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe_out,
	output logic flash_ce_n_out,
	output logic flash_we_n_out,
	output logic flash_oe_n_out,
	output logic flash_reset_n_out
);
	typedef enum {idle_type_s, cyc_setup, cyc_strobe, cyc_hold, wait_window, done_s} st_type;
	st_type state, next_state;
	word_store_if #(.depth_bits(4), .data_bits(16)) ws();
	word_store #(.depth_bits(4), .data_bits(16)) store_u (.clock_in(clock_in), .port(ws));
	// ==========================================
	// Registers
	logic [2:0] op, next_op;
	logic [addr_bits-1:0] target, next_target;
	logic [4:0] count, next_count;
	logic [4:0] step, next_step;
	logic [4:0] last_step, next_last_step;
	logic [3:0] cnt, next_cnt;
	logic [15:0] win, next_win;
	logic [15:0] status, next_status;
	logic [15:0] cyc_data;
	logic [addr_bits-1:0] cyc_addr;
	logic is_read;
	logic busy;
	assign busy = (state != idle_type_s);
	// ==========================================
	// Cycle table per step
	function automatic logic [addr_bits+15:0] unlock(input logic [4:0] s);
		unlock = (s[0] == 1'b0) ? {addr_bits'(flash_seq_pkg::unlock_addr_a), 8'h0000, flash_seq_pkg::unlock_data_a}
			: {addr_bits'(flash_seq_pkg::unlock_addr_b), 8'h0000, flash_seq_pkg::unlock_data_b};
	endfunction
	always_comb begin
		logic [addr_bits+15:0] u;
		u = unlock(step);
		cyc_addr = u[addr_bits+15:16];
		cyc_data = u[15:0];
		is_read = 1'b0;
		unique case (op)
			flash_seq_pkg::op_buffer_program: begin
				if (step == 5'd2) begin
					cyc_addr = target;
					cyc_data = {8'h0000, flash_seq_pkg::cmd_buffer_load};
				end else if (step == 5'd3) begin
					cyc_addr = target;
					cyc_data = {11'h0000, count - 5'd1}; // see [RL23]
				end else if (step >= 5'd4 && step < last_step) begin
					// Page fixed by base; loads stay within it, see [RL24] [RL5]
					cyc_addr = {target[addr_bits-1:4], 4'(step - 5'd4)};
					cyc_data = ws.rd_data; // see [RL1] [RL2]
				end else if (step == last_step) begin
					cyc_addr = target;
					cyc_data = {8'h0000, flash_seq_pkg::cmd_buffer_confirm}; // see [RL3]
				end
			end
			flash_seq_pkg::op_chip_erase, flash_seq_pkg::op_sector_erase: begin
				// Six writes, see [RL15] [RL19] [RL26]
				if (step == 5'd2) begin
					cyc_data = {8'h0000, flash_seq_pkg::cmd_erase_setup};
				end else if (step == 5'd3 || step == 5'd4) begin
					u = unlock(step - 5'd3);
					cyc_addr = u[addr_bits+15:16];
					cyc_data = u[15:0];
				end else if (step >= 5'd5) begin
					cyc_addr = (op == flash_seq_pkg::op_chip_erase) ? addr_bits'(flash_seq_pkg::unlock_addr_a) : target;
					cyc_data = {8'h0000, (op == flash_seq_pkg::op_chip_erase) ? flash_seq_pkg::cmd_chip_erase
						: flash_seq_pkg::cmd_sector_erase};
				end
			end
			flash_seq_pkg::op_suspend: cyc_data = {8'h0000, flash_seq_pkg::cmd_suspend}; // see [RL25] [RL10] [RL14]
			flash_seq_pkg::op_resume: cyc_data = {8'h0000, flash_seq_pkg::cmd_resume}; // see [RL13]
			flash_seq_pkg::op_abort_reset: begin
				if (step == 5'd2) begin
					cyc_data = {8'h0000, flash_seq_pkg::cmd_abort_reset}; // see [RL7]
				end
			end
			flash_seq_pkg::op_read: begin
				cyc_addr = target; // see [RL4]
				is_read = 1'b1;
			end
			default: ;
		endcase
	end
	// ==========================================
	// Sequencer
	logic wr_hit;
	logic wr_any_sector;
	assign wr_hit = avs_write_in && !busy;
	assign wr_any_sector = avs_write_in && state == wait_window && avs_address_in == 5'(flash_seq_pkg::reg_address)
		&& 32'(win) < window_cycles - 1;
	assign ws.wr_en = wr_hit && avs_address_in[4];
	assign ws.wr_addr = avs_address_in[3:0];
	assign ws.wr_data = avs_writedata_in[15:0];
	assign ws.rd_addr = 4'(step - 5'd4);
	always_comb begin
		next_state = state;
		next_op = op;
		next_target = target;
		next_count = count;
		next_step = step;
		next_last_step = last_step;
		next_cnt = cnt;
		next_win = win;
		next_status = status;
		unique case (state)
			idle_type_s: begin
				if (wr_hit && avs_address_in == 5'(flash_seq_pkg::reg_address)) begin
					next_target = avs_writedata_in[addr_bits-1:0];
				end
				if (wr_hit && avs_address_in == 5'(flash_seq_pkg::reg_data)) begin
					next_count = (avs_writedata_in[4:0] > 5'd16) ? 5'd16 : avs_writedata_in[4:0];
				end
				if (wr_hit && avs_address_in == 5'(flash_seq_pkg::reg_command)) begin
					next_op = avs_writedata_in[2:0];
					next_step = 5'd0;
					next_cnt = 4'd0;
					unique case (avs_writedata_in[2:0])
						flash_seq_pkg::op_buffer_program: next_last_step = 5'd4 + count;
						flash_seq_pkg::op_chip_erase, flash_seq_pkg::op_sector_erase: next_last_step = 5'd5;
						flash_seq_pkg::op_abort_reset: next_last_step = 5'd2;
						default: next_last_step = 5'd0;
					endcase
					next_state = (avs_writedata_in[2:0] == 3'h0000) ? idle_type_s : cyc_setup;
				end
			end
			cyc_setup: begin
				next_cnt = cnt + 4'd1;
				if (cnt == 4'(flash_seq_pkg::strobe_cycles - 1)) begin
					next_cnt = 4'd0;
					next_state = cyc_strobe;
				end
			end
			cyc_strobe: begin
				next_cnt = cnt + 4'd1;
				if (cnt == 4'(flash_seq_pkg::strobe_cycles - 1)) begin
					next_cnt = 4'd0;
					next_state = cyc_hold;
					if (is_read) begin
						next_status = flash_dq_in; // see [RL6] [RL9] [RL17] [RL22]
					end
				end
			end
			cyc_hold: begin
				next_cnt = cnt + 4'd1;
				if (cnt == 4'(flash_seq_pkg::strobe_cycles - 1)) begin
					next_cnt = 4'd0;
					if (step == last_step) begin
						next_win = 16'h0000;
						next_state = (op == flash_seq_pkg::op_sector_erase) ? wait_window : done_s;
					end else begin
						next_step = step + 5'd1;
						next_state = cyc_setup;
					end
				end
			end
			wait_window: begin
				// Hold off other orders until acceptance window closes, see [RL20] [RL21]
				next_win = win + 16'h0001;
				if (wr_any_sector) begin
					next_target = avs_writedata_in[addr_bits-1:0];
					next_step = 5'd5;
					next_state = cyc_setup;
				end else if (32'(win) >= window_cycles - 1) begin
					next_state = done_s;
				end
			end
			done_s: next_state = idle_type_s; // see [RL16] [RL18] [RL8] [RL11] [RL12]
			default: next_state = idle_type_s;
		endcase
	end
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			state <= idle_type_s;
			op <= 3'h0000;
			target <= '0;
			count <= 5'd1;
			step <= 5'd0;
			last_step <= 5'd0;
			cnt <= 4'd0;
			win <= 16'h0000;
			status <= 16'h0000;
		end else begin
			state <= next_state;
			op <= next_op;
			target <= next_target;
			count <= next_count;
			step <= next_step;
			last_step <= next_last_step;
			cnt <= next_cnt;
			win <= next_win;
			status <= next_status;
		end
	end
	// ==========================================
	// Pins and bus answers
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			flash_addr_out <= '0;
			flash_dq_out <= 16'h0000;
			flash_dq_oe_out <= 1'b0;
			flash_ce_n_out <= 1'b1;
			flash_we_n_out <= 1'b1;
			flash_oe_n_out <= 1'b1;
			flash_reset_n_out <= 1'b0;
		end else begin
			flash_reset_n_out <= 1'b1;
			flash_addr_out <= cyc_addr;
			flash_dq_out <= cyc_data;
			flash_dq_oe_out <= (next_state == cyc_setup || next_state == cyc_strobe || next_state == cyc_hold) && !is_read;
			flash_ce_n_out <= !(next_state == cyc_strobe || next_state == cyc_setup || next_state == cyc_hold);
			flash_we_n_out <= !(next_state == cyc_strobe && !is_read);
			flash_oe_n_out <= !(next_state == cyc_strobe && is_read);
		end
	end
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && busy && !(state == wait_window && wr_any_sector);
	always_comb begin
		avs_readdata_out = 32'h0000_0000;
		if (avs_address_in == 5'(flash_seq_pkg::reg_status)) begin
			avs_readdata_out = {15'h0000, busy, status};
		end else if (avs_address_in == 5'(flash_seq_pkg::reg_address)) begin
			avs_readdata_out = 32'(target);
		end
	end
	// ==========================================
	// Checks
	write_strobe_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see [RL26]
		!flash_we_n_out |-> !flash_ce_n_out && flash_dq_oe_out) else $error("we without ce");
	no_overlap_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see [RL4]
		!(flash_we_n_out == 1'b0 && flash_oe_n_out == 1'b0)) else $error("we and oe low");
	confirm_data_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see [RL3]
		(state == cyc_strobe && op == flash_seq_pkg::op_buffer_program && step == last_step)
		|-> flash_addr_out == target && flash_dq_out[7:0] == flash_seq_pkg::cmd_buffer_confirm)
		else $error("bad confirm");
	count_word_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see [RL23]
		(state == cyc_strobe && op == flash_seq_pkg::op_buffer_program && step == 5'd3)
		|-> flash_dq_out == 16'(count - 5'd1)) else $error("bad count");
	page_fixed_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see [RL24]
		(state == cyc_strobe && op == flash_seq_pkg::op_buffer_program && step >= 5'd4 && step < last_step)
		|-> flash_addr_out[addr_bits-1:4] == target[addr_bits-1:4]) else $error("page left");
	chip_final_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see [RL15]
		(state == cyc_strobe && op == flash_seq_pkg::op_chip_erase && step == 5'd5)
		|-> flash_dq_out[7:0] == flash_seq_pkg::cmd_chip_erase) else $error("bad chip erase");
	sector_final_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see [RL19]
		(state == cyc_strobe && op == flash_seq_pkg::op_sector_erase && step == 5'd5)
		|-> flash_addr_out == target && flash_dq_out[7:0] == flash_seq_pkg::cmd_sector_erase)
		else $error("bad sector");
	setup_cmd_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see [RL15]
		(state == cyc_strobe && (op == flash_seq_pkg::op_chip_erase || op == flash_seq_pkg::op_sector_erase)
		&& step == 5'd2) |-> flash_dq_out[7:0] == flash_seq_pkg::cmd_erase_setup) else $error("bad setup");
	window_bound_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // see [RL20]
		state == wait_window |-> 32'(win) < window_cycles) else $error("window overrun");
	cover_buffer_c: cover property (@(posedge clock_in) state == cyc_hold && op == flash_seq_pkg::op_buffer_program);
	cover_sector_c: cover property (@(posedge clock_in) state == wait_window);
	cover_chip_c: cover property (@(posedge clock_in) state == done_s && op == flash_seq_pkg::op_chip_erase);
endmodule

// ### verif/flash_device_model.sv
// Flash device model: command decode, small word array, status on the data lines
module flash_device_model #(parameter int busy_ns = 500, parameter int win_ns = 1250) (
	// Bus from the host
	input wire logic [21:0] addr_in,
	input wire logic [15:0] dq_in,
	input wire logic dq_oe_in,
	input wire logic ce_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	input wire logic reset_n_in,
	// Data lines seen by the host
	output logic [15:0] dq_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:255];
	logic [15:0] bw [0:255];
	logic [255:0] ld;
	logic [21:0] log_a [0:63];
	logic [15:0] log_d [0:63];
	logic [21:0] sector_address;
	logic [17:0] pg;
	logic [15:0] rd = 16'h0000;
	logic [15:0] last = 16'h0000;
	logic [15:0] ldv = 16'h0000;
	logic [7:0] c;
	logic tog = 1'b0;
	logic abt = 1'b0;
	logic susp = 1'b0;
	logic chip = 1'b0;
	int log_n = 0;
	int st = 0;
	int left = 0;
	realtime b_end = 0;
	realtime w_end = 0;
	realtime rem = 0;
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	function automatic logic [7:0] ix(input logic [21:0] a);
		return {a[15], a[6:0]};
	endfunction
	task automatic erase(input logic [21:0] a);
		for (int i = 0; i < 256; i++) if (i[7] == a[15]) mem[i] = 16'hFFFF;
		w_end = $realtime + win_ns;
		b_end = w_end + busy_ns;
	endtask
	// Released bus shows the inverse of the last value
	assign dq_out = dq_oe_in ? dq_in : (!oe_n_in && !ce_n_in) ? rd : ~last;
	always @(posedge oe_n_in) last = rd;
	always @(negedge oe_n_in) if (!ce_n_in) begin
		tog = ~tog;
		if (abt || ($realtime < b_end && !susp)) begin
			rd = 16'h0000;
			rd[7] = ~ldv[7];
			rd[6] = tog;
			rd[3] = $realtime >= w_end;
			rd[2] = tog;
			rd[1] = abt;
		end else rd = mem[ix(addr_in)];
	end
	always @(negedge reset_n_in) begin
		b_end = 0;
		susp = 0;
		abt = 0;
		st = 0;
	end
	always @(posedge we_n_in) if (!ce_n_in && reset_n_in) begin
		c = dq_in[7:0];
		log_a[log_n] = addr_in;
		log_d[log_n] = dq_in;
		log_n++;
		if (susp) begin
			if (c == 8'h30) begin
				susp = 0;
				b_end = $realtime + rem;
			end
		end else if ($realtime < b_end) begin
			if ($realtime < w_end && c == 8'h30) erase(addr_in);
			else if (c == 8'hB0 && !chip) begin
				susp = 1;
				rem = b_end - $realtime;
			end else if ($realtime < w_end) b_end = 0;
		end else case (st)
			0: st = (c == 8'hAA && addr_in[11:0] == 12'h555) ? 1 : 0;
			1: st = (c == 8'h55 && addr_in[11:0] == 12'h2AA) ? 2 : 0;
			2: begin
				abt = abt && c != 8'hF0;
				st = abt ? 0 : c == 8'h80 ? 3 : c == 8'h25 ? 6 : 0;
				sector_address = addr_in;
			end
			3: st = (c == 8'hAA) ? 4 : 0;
			4: st = (c == 8'h55) ? 5 : 0;
			5: begin
				st = 0;
				chip = c == 8'h10;
				if (chip) begin
					foreach (mem[i]) mem[i] = 16'hFFFF;
					b_end = $realtime + busy_ns;
				end else if (c == 8'h30) erase(addr_in);
			end
			6: begin
				left = dq_in + 1;
				ld = '0;
				abt = dq_in > 15;
				st = abt ? 0 : 7;
			end
			7: begin
				if (ld == '0) pg = addr_in[21:4];
				abt = addr_in[21:4] != pg || addr_in[21:15] != sector_address[21:15];
				bw[ix(addr_in)] = dq_in;
				ld[ix(addr_in)] = 1'b1;
				ldv = dq_in;
				left--;
				st = abt ? 0 : left == 0 ? 8 : 7;
			end
			default: begin
				abt = c != 8'h29 || addr_in[21:15] != sector_address[21:15];
				st = 0;
				if (!abt) begin
					for (int i = 0; i < 256; i++) if (ld[i]) mem[i] = mem[i] & bw[i];
					b_end = $realtime + busy_ns;
				end
			end
		endcase
	end
endmodule

// ### verif/flash_seq_host_test.sv
// Testbench: register-level tests of the flash sequencer against the device model
module flash_seq_host_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] a_cmd = {1'b0, flash_seq_pkg::reg_command};
	localparam logic [4:0] a_adr = {1'b0, flash_seq_pkg::reg_address};
	localparam logic [4:0] a_cnt = {1'b0, flash_seq_pkg::reg_data};
	localparam logic [4:0] a_sts = {1'b0, flash_seq_pkg::reg_status};
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [4:0] avs_address_in = 5'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0000_0000;
	logic [31:0] avs_readdata_out;
	logic [31:0] rdata;
	logic avs_waitrequest_out;
	logic [21:0] f_addr;
	logic [15:0] f_dq_in;
	logic [15:0] f_dq_out;
	logic f_oe;
	logic f_ce_n;
	logic f_we_n;
	logic f_oe_n;
	logic f_rst_n;
	int miscompares = 0;
	int samples_checked = 0;
	int rp = 0;
	always #12.5 clock_in = ~clock_in;
	flash_seq_host #(.addr_bits(22), .window_cycles(50)) u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .flash_addr_out(f_addr), .flash_dq_in(f_dq_in),
		.flash_dq_out(f_dq_out), .flash_dq_oe_out(f_oe), .flash_ce_n_out(f_ce_n), .flash_we_n_out(f_we_n),
		.flash_oe_n_out(f_oe_n), .flash_reset_n_out(f_rst_n));
	flash_device_model u_model (.addr_in(f_addr), .dq_in(f_dq_out), .dq_oe_in(f_oe), .ce_n_in(f_ce_n),
		.we_n_in(f_we_n), .oe_n_in(f_oe_n), .reset_n_in(f_rst_n), .dq_out(f_dq_in));
	// ==========================================
	// Bus and compare tasks
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
		rdata = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge clock_in);
	endtask
	task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cyc(input logic [21:0] a, input logic [21:0] am, input logic [15:0] d, input logic [15:0] dm);
		check("cycle address", {10'h000, a & am}, {10'h000, u_model.log_a[rp] & am});
		check("cycle data", {16'h0000, d & dm}, {16'h0000, u_model.log_d[rp] & dm});
		rp++;
	endtask
	task automatic unl();
		cyc(22'h000555, 22'h000FFF, 16'h00AA, 16'h00FF);
		cyc(22'h0002AA, 22'h000FFF, 16'h0055, 16'h00FF);
	endtask
	task automatic esq();
		unl();
		cyc(22'h000555, 22'h000FFF, 16'h0080, 16'h00FF);
		unl();
	endtask
	task automatic op(input logic [2:0] c);
		bus(1'b1, a_cmd, {29'h0000_0000, c});
		bus(1'b0, a_sts, 32'h0000_0000);
	endtask
	task automatic prog(input logic [21:0] a, input int n, input logic [15:0] w0);
		int k;
		k = n > 16 ? 16 : n;
		bus(1'b1, a_adr, {10'h000, a});
		bus(1'b1, a_cnt, 32'(n));
		for (int i = 0; i < k; i++) bus(1'b1, 5'h10 + 5'(i), {16'h0000, w0 + 16'(i)});
		op(flash_seq_pkg::op_buffer_program);
		unl();
		cyc(a, 22'h3F_8000, 16'h0025, 16'h00FF);
		cyc(a, 22'h3F_8000, 16'(k - 1), 16'h00FF);
		for (int i = 0; i < k; i++) cyc({a[21:4], 4'(i)}, 22'h3F_FFFF, w0 + 16'(i), 16'hFFFF);
		cyc(a, 22'h3F_8000, 16'h0029, 16'h00FF);
	endtask
	// Poll until two reads agree, then compare the settled word
	task automatic rdw(input logic [21:0] a, input logic [15:0] e);
		logic [15:0] prev;
		int n;
		n = 0;
		bus(1'b1, a_adr, {10'h000, a});
		op(flash_seq_pkg::op_read);
		prev = ~rdata[15:0];
		while (rdata[15:0] !== prev && n < 40) begin
			prev = rdata[15:0];
			op(flash_seq_pkg::op_read);
			n++;
		end
		check("read word", {15'h0000, 1'b0, e}, {15'h0000, rdata[16:0]});
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================
	// Test sequence
	initial begin
		repeat (5) @(posedge clock_in);
		check("reset pin", 32'h0000_0000, {31'h0000_0000, f_rst_n});
		rst_n_in <= 1'b1;
		@(posedge clock_in);
		prog(22'h00_0040, 2, 16'hA5A0);
		rdw(22'h00_0041, 16'hA5A1);
		rdw(22'h00_0040, 16'hA5A0);
		prog(22'h00_0040, 1, 16'h0F0F);
		rdw(22'h00_0040, 16'h0500);
		prog(22'h00_0080, 17, 16'h1000);
		rdw(22'h00_008F, 16'h100F);
		op(flash_seq_pkg::op_suspend);
		cyc(22'h00_0000, 22'h00_0000, 16'h00B0, 16'h00FF);
		op(flash_seq_pkg::op_resume);
		cyc(22'h00_0000, 22'h00_0000, 16'h0030, 16'h00FF);
		op(flash_seq_pkg::op_abort_reset);
		unl();
		cyc(22'h00_0555, 22'h00_0FFF, 16'h00F0, 16'h00FF);
		op(flash_seq_pkg::op_chip_erase);
		esq();
		cyc(22'h00_0555, 22'h00_0FFF, 16'h0010, 16'h00FF);
		rdw(22'h00_0040, 16'hFFFF);
		bus(1'b1, a_adr, 32'h0000_8000);
		bus(1'b1, a_cmd, {29'h0000_0000, flash_seq_pkg::op_sector_erase});
		bus(1'b1, a_adr, 32'h0001_0000);
		bus(1'b0, a_sts, 32'h0000_0000);
		esq();
		cyc(22'h00_8000, 22'h3F_8000, 16'h0030, 16'h00FF);
		cyc(22'h01_0000, 22'h3F_8000, 16'h0030, 16'h00FF);
		// Window has run out while the erase is still busy
		op(flash_seq_pkg::op_read);
		check("erase timer", 32'h0000_0001, {31'h0000_0000, rdata[flash_seq_pkg::erase_timer_flag]});
		rdw(22'h00_8000, 16'hFFFF);
		check("cycle count", 32'(rp), 32'(u_model.log_n));
		results();
	end
	initial begin
		repeat (20000) @(posedge clock_in);
		miscompares++;
		results();
	end
endmodule
